// *** logic/sfr_pkg.sv ***
// Constants and types for the serial flash read and soft reset block
// Function
// (RULE1) Accepted soft reset aborts work and clears volatile bits, latch, mode, wrap
// (RULE2) Reset happens only for 66h followed directly by 99h
// (RULE3) Any instruction other than 99h after 66h drops the armed state
// (RULE4) About 300 us of reset follow 99h; every instruction is refused then
// (RULE5) Host should poll busy and suspend flags before the reset pair
// (RULE6) 03h: serial 3-byte address on rising edges, data on SO falling edges
// (RULE7) Address advances per output byte; streaming runs until select rises
// (RULE8) Reads during a self-timed cycle are ignored; the cycle continues
// (RULE9) 0Bh: serial address plus dummy byte, then serial data from any address
// (RULE10) 3Bh: serial address plus dummy byte, then data two bits per clock
// (RULE11) 6Bh: serial address plus dummy byte, data four bits; needs quad enable
// (RULE12) BBh: address and mode byte two bits per clock, data two bits per clock
// (RULE13) Mode bits 5:4 equal 10 skip the opcode on the next transaction
// (RULE14) Host may clear mode bits 5:4 before a normal instruction
// (RULE15) EBh: address, mode byte, 4 dummy clocks, data, all four bits per clock
// (RULE16) EBh runs only while quad enable is set; continuous-mode EBh frames skip the quad enable check
// (RULE17) Quad enable sits at status bit 9 and gates four-line reads
// (RULE18) Wrap enable bit defaults to 1 (wrap off) at power-on and soft reset
// (RULE19) Write-in-progress reads 1 during a self-timed cycle, 0 after
// (RULE20) Select high releases data lines and drops any partial field
package sfr_pkg;
   localparam logic [7:0] CMD_ARM  = 8'h66;
   localparam logic [7:0] CMD_RST  = 8'h99;
   localparam logic [7:0] CMD_READ = 8'h03;
   localparam logic [7:0] CMD_FAST = 8'h0B;
   localparam logic [7:0] CMD_DOUT = 8'h3B;
   localparam logic [7:0] CMD_QOUT = 8'h6B;
   localparam logic [7:0] CMD_DIO  = 8'hBB;
   localparam logic [7:0] CMD_QIO  = 8'hEB;
   localparam int RST_TIME_US = 300;
   localparam int CLK_MHZ     = 100;
   localparam int RST_CYC_DEF = RST_TIME_US * CLK_MHZ;
   localparam int WIP_CYC_DEF = 1000;
   localparam int ADDR_W      = 24;
   localparam int MODE_W      = 8;
   localparam int DUMMY_SER   = 8;
   localparam int DUMMY_QIO   = 4;
   localparam int AXI_AW      = 8;
   localparam logic [7:0] REG_CTRL  = 8'h00;
   localparam logic [7:0] REG_STAT  = 8'h04;
   localparam logic [7:0] REG_MADDR = 8'h08;
   localparam logic [7:0] REG_MDATA = 8'h0C;
   localparam int B_WIP  = 0;
   localparam int B_WEL  = 1;
   localparam int B_QE   = 9;
   localparam int B_SUS  = 15;
   localparam int B_ARM  = 16;
   localparam int B_RSTG = 17;
   localparam int B_CONT = 18;
   localparam int B_WRAP = 20;
   localparam logic [2:0] WRAP_RST = 3'h1;
   localparam logic [1:0] CONT_KEY = 2'h2;
   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;

   typedef enum logic [6:0] {
      ST_IDLE  = 7'h01,
      ST_CMD   = 7'h02,
      ST_ADDR  = 7'h04,
      ST_MODE  = 7'h08,
      ST_DUMMY = 7'h10,
      ST_DATA  = 7'h20,
      ST_SKIP  = 7'h40
   } sfr_state_t;

   typedef struct packed {
      logic       sclk;
      logic       cs_n;
      logic [3:0] io;
   } sfr_pins_t;

   typedef struct packed {
      sfr_state_t  state;
      logic [4:0]  cnt;
      logic [7:0]  sh;
      logic [7:0]  cmd;
      logic [23:0] addr;
      logic [7:0]  mode;
      logic        cont;
      logic [7:0]  cont_cmd;
      logic        armed;
      logic        qe;
      logic        write_enable_latch;
      logic        suspend_flag;
      logic [2:0]  wrap;
      logic [31:0] wip_cnt;
      logic [31:0] rst_cnt;
      logic [3:0]  io_out;
      logic [3:0]  io_oe;
      logic        aw_hold;
      logic [7:0]  aw_addr;
      logic        w_hold;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [23:0] maddr;
   } sfr_regs_t;

   localparam sfr_regs_t REGS_RST = '{
      state: ST_IDLE, wrap: WRAP_RST, awready: 1'b1, wready: 1'b1,
      arready: 1'b1, default: '0};
endpackage

// *** logic/sfr_flash_read.sv ***
// Serial flash read sequencer with soft reset and AXI4-Lite registers
`timescale 1ns/1ps
module sfr_flash_read
   import sfr_pkg::*;
#(
   parameter int RST_CYCLES = RST_CYC_DEF,
   parameter int WIP_CYCLES = WIP_CYC_DEF,
   parameter int MEM_AW     = 8
)
(
   input  wire logic              i_clock,
   input  wire logic              i_resetn,
   input  wire logic              i_ce,
   input  wire sfr_pins_t         i_spi,
   output logic [3:0]             o_io_out,
   output logic [3:0]             o_io_oe,
   input  wire logic [AXI_AW-1:0] i_awaddr,
   input  wire logic              i_awvalid,
   output logic                   o_awready,
   input  wire logic [31:0]       i_wdata,
   input  wire logic [3:0]        i_wstrb,
   input  wire logic              i_wvalid,
   output logic                   o_wready,
   output logic [1:0]             o_bresp,
   output logic                   o_bvalid,
   input  wire logic              i_bready,
   input  wire logic [AXI_AW-1:0] i_araddr,
   input  wire logic              i_arvalid,
   output logic                   o_arready,
   output logic [31:0]            o_rdata,
   output logic [1:0]             o_rresp,
   output logic                   o_rvalid,
   input  wire logic              i_rready
);
   logic [1:0]  rsn_ff;
   logic        rsn;
   sfr_pins_t   s1_ff;
   sfr_pins_t   s2_ff;
   sfr_pins_t   s3_ff;
   sfr_pins_t   stable_ff;
   sfr_pins_t   pin;
   logic [5:0]  agree;
   logic        rise;
   logic        fall;
   sfr_regs_t   r_ff;
   sfr_regs_t   nxt;
   logic [7:0]  mem [2**MEM_AW];
   logic        mem_we;
   logic        do_reset;
   logic        busy;
   logic        resetting;
   logic [2:0]  iw;
   logic [2:0]  ow;
   logic [4:0]  addr_last;
   logic [4:0]  mode_last;
   logic [4:0]  dummy_last;
   logic [31:0] stat_word;
   logic [7:0]  ob;
   logic [23:0] addr_in;
   logic [23:0] mode_in;

   // Reset release through two flops
   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
         rsn_ff <= 2'h0;
      else
         rsn_ff <= {rsn_ff[0], 1'b1};
   end
   assign rsn = rsn_ff[1];

   // Pin sampling; a change counts once stages two and three agree
   assign agree = ~(s2_ff ^ s3_ff);
   assign pin   = (agree & s3_ff) | (~agree & stable_ff);
   assign rise  = pin.sclk & ~stable_ff.sclk;
   assign fall  = ~pin.sclk & stable_ff.sclk;

   always_ff @(posedge i_clock or negedge rsn)
   begin
      if (!rsn)
      begin
         s1_ff     <= 6'h3F;
         s2_ff     <= 6'h3F;
         s3_ff     <= 6'h3F;
         stable_ff <= 6'h3F;
      end
      else if (i_ce)
      begin
         s1_ff     <= i_spi;
         s2_ff     <= s1_ff;
         s3_ff     <= s2_ff;
         stable_ff <= pin;
      end
   end

   function automatic logic [23:0] shin(input logic [23:0] v,
                                        input logic [3:0]  d,
                                        input logic [2:0]  w);
      logic [23:0] res;
      res = {v[22:0], d[0]};
      if (w == 3'h4)
         res = {v[19:0], d};
      else if (w == 3'h2)
         res = {v[21:0], d[1:0]};
      return res;
   endfunction

   assign busy      = r_ff.wip_cnt != 32'h0;
   assign resetting = r_ff.rst_cnt != 32'h0;
   assign iw = (r_ff.cmd == CMD_QIO) ? 3'h4 :
               (r_ff.cmd == CMD_DIO) ? 3'h2 : 3'h1;
   assign ow = (r_ff.cmd == CMD_QIO || r_ff.cmd == CMD_QOUT) ? 3'h4 :
               (r_ff.cmd == CMD_DIO || r_ff.cmd == CMD_DOUT) ? 3'h2 : 3'h1;
   assign addr_last  = 5'(ADDR_W / int'(iw) - 1);
   assign mode_last  = 5'(MODE_W / int'(iw) - 1);
   assign dummy_last = 5'(((r_ff.cmd == CMD_QIO) ? DUMMY_QIO : DUMMY_SER) - 1);
   assign ob = (r_ff.cnt == 5'h0) ? mem[r_ff.addr[MEM_AW-1:0]] : r_ff.sh;
   assign addr_in = shin(r_ff.addr, pin.io, iw);
   assign mode_in = shin({16'h0, r_ff.mode}, pin.io, iw);

   always_comb
   begin
      stat_word         = 32'h0;
      stat_word[B_WIP]  = busy;   // see RULE19
      stat_word[B_WEL]  = r_ff.write_enable_latch;
      stat_word[B_QE]   = r_ff.qe;   // see RULE17
      stat_word[B_SUS]  = r_ff.suspend_flag;
      stat_word[B_ARM]  = r_ff.armed;
      stat_word[B_RSTG] = resetting;
      stat_word[B_CONT] = r_ff.cont;
      stat_word[B_WRAP +: 3] = r_ff.wrap;
   end

   always_comb
   begin
      nxt      = r_ff;
      mem_we   = 1'b0;
      do_reset = 1'b0;
      // Self-timed cycle and reset timers
      if (busy)
      begin
         nxt.wip_cnt = r_ff.wip_cnt - 32'h1;
         if (r_ff.wip_cnt == 32'h1)
            nxt.write_enable_latch = 1'b0;
      end
      if (resetting)
         nxt.rst_cnt = r_ff.rst_cnt - 32'h1;
      // Register writes
      if (i_awvalid && r_ff.awready)
      begin
         nxt.aw_hold = 1'b1;
         nxt.aw_addr = i_awaddr;
      end
      if (i_wvalid && r_ff.wready)
      begin
         nxt.w_hold = 1'b1;
         nxt.wdata  = i_wdata;
         nxt.wstrb  = i_wstrb;
      end
      if (r_ff.bvalid && i_bready)
         nxt.bvalid = 1'b0;
      if (r_ff.aw_hold && r_ff.w_hold && !r_ff.bvalid)
      begin
         nxt.aw_hold = 1'b0;
         nxt.w_hold  = 1'b0;
         nxt.bvalid  = 1'b1;
         nxt.bresp   = RESP_OK;
         case (r_ff.aw_addr)
            REG_CTRL:
            begin
               if (r_ff.wstrb[0])
               begin
                  nxt.write_enable_latch = r_ff.wdata[B_WEL];
                  if (r_ff.wdata[B_WIP] && !busy)
                     nxt.wip_cnt = 32'(WIP_CYCLES);   // see RULE19
               end
               if (r_ff.wstrb[1])
               begin
                  nxt.qe  = r_ff.wdata[B_QE];
                  nxt.suspend_flag = r_ff.wdata[B_SUS];
               end
            end
            REG_STAT:
               nxt.bresp = RESP_OK;
            REG_MADDR:
               if (|r_ff.wstrb)
                  nxt.maddr = r_ff.wdata[23:0];
            REG_MDATA:
               if (r_ff.wstrb[0])
               begin
                  mem_we    = 1'b1;
                  nxt.maddr = r_ff.maddr + 24'h1;
               end
            default:
               nxt.bresp = RESP_ERR;
         endcase
      end
      nxt.awready = !nxt.aw_hold;
      nxt.wready  = !nxt.w_hold;
      // Register reads
      if (r_ff.rvalid && i_rready)
         nxt.rvalid = 1'b0;
      if (i_arvalid && r_ff.arready)
      begin
         nxt.rvalid = 1'b1;
         nxt.rresp  = RESP_OK;
         case (i_araddr)
            REG_CTRL,
            REG_STAT:  nxt.rdata = stat_word;
            REG_MADDR: nxt.rdata = {8'h0, r_ff.maddr};
            REG_MDATA: nxt.rdata = {24'h0, mem[r_ff.maddr[MEM_AW-1:0]]};
            default:
            begin
               nxt.rdata = 32'h0;
               nxt.rresp = RESP_ERR;
            end
         endcase
      end
      nxt.arready = !nxt.rvalid;
      // Serial link
      if (pin.cs_n)
      begin
         nxt.state = ST_IDLE;   // see RULE20
         nxt.io_oe = 4'h0;   // see RULE20
      end
      else
      begin
         unique case (r_ff.state)
            ST_IDLE:
            begin
               nxt.cnt = 5'h0;
               nxt.state = ST_CMD;
               if (r_ff.cont && !resetting)
               begin
                  nxt.armed = 1'b0;   // see RULE3
                  nxt.cmd   = r_ff.cont_cmd;   // see RULE13
                  nxt.state = busy ? ST_SKIP : ST_ADDR;   // see RULE8
               end
            end
            ST_CMD:
               if (rise)
               begin
                  nxt.sh  = {r_ff.sh[6:0], pin.io[0]};
                  nxt.cnt = r_ff.cnt + 5'h1;
                  if (r_ff.cnt == 5'h7)
                  begin
                     nxt.cnt   = 5'h0;
                     nxt.cmd   = nxt.sh;
                     nxt.state = ST_SKIP;
                     nxt.armed = 1'b0;   // see RULE3
                     if (!resetting)   // see RULE4
                     begin
                        if (nxt.sh == CMD_ARM)
                           nxt.armed = 1'b1;   // see RULE2
                        else if (nxt.sh == CMD_RST && r_ff.armed)
                           do_reset = 1'b1;   // see RULE2
                        else if ((nxt.sh == CMD_READ || nxt.sh == CMD_FAST ||
                                  nxt.sh == CMD_DOUT || nxt.sh == CMD_DIO ||
                                  ((nxt.sh == CMD_QOUT || nxt.sh == CMD_QIO)
                                   && r_ff.qe)) && !busy)   // see RULE16
                           nxt.state = ST_ADDR;   // see RULE8
                     end
                  end
               end
            ST_ADDR:
               if (rise)
               begin
                  nxt.addr = addr_in;   // see RULE6
                  nxt.cnt  = r_ff.cnt + 5'h1;
                  if (r_ff.cnt == addr_last)
                  begin
                     nxt.cnt = 5'h0;
                     if (r_ff.cmd == CMD_DIO || r_ff.cmd == CMD_QIO)
                        nxt.state = ST_MODE;   // see RULE12
                     else if (r_ff.cmd == CMD_READ)
                        nxt.state = ST_DATA;   // see RULE6
                     else
                        nxt.state = ST_DUMMY;   // see RULE9
                  end
               end
            ST_MODE:
               if (rise)
               begin
                  nxt.mode = mode_in[7:0];
                  nxt.cnt  = r_ff.cnt + 5'h1;
                  if (r_ff.cnt == mode_last)
                  begin
                     nxt.cnt      = 5'h0;
                     nxt.cont     = (nxt.mode[5:4] == CONT_KEY);   // see RULE13
                     nxt.cont_cmd = r_ff.cmd;
                     nxt.state    = (r_ff.cmd == CMD_QIO) ?
                                    ST_DUMMY : ST_DATA;   // see RULE15
                  end
               end
            ST_DUMMY:
               if (rise)
               begin
                  nxt.cnt = r_ff.cnt + 5'h1;
                  if (r_ff.cnt == dummy_last)
                  begin
                     nxt.cnt   = 5'h0;
                     nxt.state = ST_DATA;   // see RULE10
                  end
               end
            ST_DATA:
               if (fall)
               begin
                  if (r_ff.cnt == 5'h0)
                     nxt.addr = r_ff.addr + 24'h1;   // see RULE7
                  if (ow == 3'h4)
                  begin
                     nxt.io_out = ob[7:4];   // see RULE11
                     nxt.io_oe  = 4'hF;
                  end
                  else if (ow == 3'h2)
                  begin
                     nxt.io_out = {2'h0, ob[7:6]};   // see RULE10
                     nxt.io_oe  = 4'h3;
                  end
                  else
                  begin
                     nxt.io_out = {2'h0, ob[7], 1'b0};   // see RULE6
                     nxt.io_oe  = 4'h2;
                  end
                  nxt.sh  = 8'(ob << ow);
                  nxt.cnt = (r_ff.cnt + {2'h0, ow}) & 5'h7;
               end
            ST_SKIP:
               nxt.io_oe = 4'h0;
         endcase
      end
      if (do_reset)
      begin
         nxt.rst_cnt = 32'(RST_CYCLES);   // see RULE4
         nxt.wip_cnt = 32'h0;   // see RULE1
         nxt.write_enable_latch     = 1'b0;
         nxt.suspend_flag     = 1'b0;
         nxt.qe      = 1'b0;
         nxt.cont    = 1'b0;
         nxt.mode    = 8'h0;
         nxt.armed   = 1'b0;
         nxt.wrap    = WRAP_RST;   // see RULE18
      end
   end

   always_ff @(posedge i_clock or negedge rsn)
   begin
      if (!rsn)
         r_ff <= REGS_RST;
      else if (i_ce)
         r_ff <= nxt;
   end

   always_ff @(posedge i_clock)
   begin
      if (i_ce && mem_we)
         mem[r_ff.maddr[MEM_AW-1:0]] <= r_ff.wdata[7:0];
   end

   assign o_io_out  = r_ff.io_out;
   assign o_io_oe   = r_ff.io_oe;
   assign o_awready = r_ff.awready;
   assign o_wready  = r_ff.wready;
   assign o_bresp   = r_ff.bresp;
   assign o_bvalid  = r_ff.bvalid;
   assign o_arready = r_ff.arready;
   assign o_rdata   = r_ff.rdata;
   assign o_rresp   = r_ff.rresp;
   assign o_rvalid  = r_ff.rvalid;
endmodule

// *** sim/sfr_chk_sva.sv ***
// Port checker for the flash read block
`timescale 1ns/1ps
module sfr_chk
   import sfr_pkg::*;
(
   input wire logic              i_clock,
   input wire logic              i_resetn,
   input wire sfr_pins_t         i_spi,
   input wire logic [3:0]        o_io_out,
   input wire logic [3:0]        o_io_oe,
   input wire logic              i_awvalid,
   input wire logic              o_awready,
   input wire logic              i_wvalid,
   input wire logic              o_wready,
   input wire logic [1:0]        o_bresp,
   input wire logic              o_bvalid,
   input wire logic              i_bready,
   input wire logic [AXI_AW-1:0] i_araddr,
   input wire logic              i_arvalid,
   input wire logic              o_arready,
   input wire logic [31:0]       o_rdata,
   input wire logic [1:0]        o_rresp,
   input wire logic              o_rvalid,
   input wire logic              i_rready
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_resetn);

   oe_release_a: assert property (
      i_spi.cs_n [*8] |-> o_io_oe == 4'h0)
      else $error("lines driven with select high");
   oe_start_a: assert property (
      $rose(|o_io_oe) |-> !i_spi.cs_n)
      else $error("drive started outside a frame");
   lane_set_a: assert property (
      o_io_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
      else $error("bad lane enable");
   out_edge_a: assert property (
      (|o_io_oe) && $changed(o_io_out) |-> !i_spi.sclk)
      else $error("data changed with clock high");
   b_resp_a: assert property (
      i_awvalid && o_awready && i_wvalid && o_wready
      |=> !o_awready ##[0:1] o_bvalid)
      else $error("write response missing");
   b_hold_a: assert property (
      o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped");
   r_resp_a: assert property (
      i_arvalid && o_arready |=> o_rvalid && !o_arready)
      else $error("read response late");
   r_hold_a: assert property (
      o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read response dropped");
   r_err_a: assert property (
      i_arvalid && o_arready && i_araddr > 8'h0C
      |=> o_rresp == RESP_ERR && o_rdata == 32'h0)
      else $error("unmapped read not refused");
endmodule

bind sfr_flash_read sfr_chk u_chk (.i_clock(i_clock), .i_resetn(i_resetn),
   .i_spi(i_spi), .o_io_out(o_io_out), .o_io_oe(o_io_oe),
   .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid),
   .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
   .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
   .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
   .o_rvalid(o_rvalid), .i_rready(i_rready));

// *** sim/sfr_host.sv ***
// Host controller model issuing flash read frames
`timescale 1ns/1ps
module sfr_host
   import sfr_pkg::*;
(
   input  wire logic [3:0] i_out,
   input  wire logic [3:0] i_oe,
   output sfr_pins_t       o_spi
);
   logic       sclk = 1'b0;
   logic       cs_n = 1'b1;
   logic [3:0] hdrv = 4'h0;
   logic [3:0] io_w;
   assign io_w = (i_oe & i_out) | (~i_oe & hdrv);
   assign o_spi = {sclk, cs_n, io_w};

   // Bits go out MSB first, taken on the rising clock
   task automatic sh(input logic [31:0] v, input int n, input int ln);
      repeat (n / ln)
      begin
         hdrv = ln == 4 ? v[31:28] : ln == 2 ? {hdrv[3:2], v[31:30]}
            : {hdrv[3:1], v[31]};
         v = v << ln;
         #80 sclk = 1'b1;
         #80 sclk = 1'b0;
      end
   endtask

   task automatic xfer(input logic [7:0] op, input bit hop,
      input logic [23:0] a, input int al, input logic [7:0] m,
      input int hm, input int dc, input int dl,
      output logic [15:0] d, output logic seen);
      d = 16'h0;
      seen = 1'b0;
      cs_n = 1'b0;
      if (hop) sh({op, 24'h0}, 8, 1);
      if (al > 0) sh({a, 8'h0}, 24, al);
      if (hm > 0) sh({m, 24'h0}, 8, al);
      if (dc > 0) sh(32'h5A5A_5A5A, dc, 1);
      repeat (dl > 0 ? 16 / dl : 0)
      begin
         #80 sclk = 1'b1;
         d = (d << dl) | (dl == 4 ? io_w : dl == 2 ? io_w[1:0] : io_w[1]);
         seen = seen | (|i_oe);
         #80 sclk = 1'b0;
         hdrv = ~hdrv;
      end
      #80 cs_n = 1'b1;
      hdrv = ~hdrv;
      #200;
   endtask
endmodule

// *** sim/tb.sv ***
// Self-checking bench for the flash read block
`timescale 1ns/1ps
module tb
   import sfr_pkg::*;
();
   localparam int RSTC = 2000;
   localparam int WIPC = 1500;
   typedef struct {
      logic [7:0]  op;
      int          al, hm, dc, dl;
      logic [7:0]  a;
      logic [15:0] ex;
   } sfr_row_t;
   logic [7:0] mb [5] = '{8'hA5, 8'h3C, 8'h0F, 8'hD2, 8'h81};
   sfr_row_t rows [6] = '{
      '{CMD_READ, 1, 0, 0, 1, 8'h10, 16'hA53C},
      '{CMD_FAST, 1, 0, 8, 1, 8'h11, 16'h3C0F},
      '{CMD_DOUT, 1, 0, 8, 2, 8'h12, 16'h0FD2},
      '{CMD_QOUT, 1, 0, 8, 4, 8'h13, 16'hD281},
      '{CMD_DIO,  2, 1, 0, 2, 8'h10, 16'hA53C},
      '{CMD_QIO,  4, 1, 4, 4, 8'h11, 16'h3C0F}};
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0, rd;
   logic [3:0]  wstrb = 4'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, seen;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, rr, rb;
   logic [31:0] rdata;
   logic [3:0]  io_out, io_oe;
   logic [15:0] d;
   sfr_pins_t   spi;
   int          error_cnt = 0, n_checks = 0, cyc = 0;
   bit          stall = 1'b0;

   sfr_flash_read #(.RST_CYCLES(RSTC), .WIP_CYCLES(WIPC)) uut (
      .i_clock(clk), .i_resetn(rstn), .i_ce(1'b1), .i_spi(spi),
      .o_io_out(io_out), .o_io_oe(io_oe), .i_awaddr(awaddr),
      .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
      .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
      .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
      .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
      .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
      .i_rready(rready));
   sfr_host host (.i_out(io_out), .i_oe(io_oe), .o_spi(spi));

   initial forever #5 clk = ~clk;

   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         error_cnt++;
         finish_test();
      end
   end

   task automatic chk(input string nm, input logic [31:0] ex,
      input logic [31:0] got);
      n_checks++;
      if (got !== ex)
      begin
         $display("[FAIL] %s exp %h got %h", nm, ex, got);
         error_cnt++;
      end
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] v,
      input logic [3:0] s);
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= !stall;
      do
      begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && !bready) bready <= 1'b1;
      end while (!(bvalid && bready));
      rb = bresp;
      bready <= 1'b0;
   endtask

   task automatic axr(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= !stall;
      do
      begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && !rready) rready <= 1'b1;
      end while (!(rvalid && rready));
      rd = rdata;
      rr = rresp;
      rready <= 1'b0;
   endtask

   // Opcode-only frame
   task automatic op1(input logic [7:0] c);
      host.xfer(c, 1'b1, 24'h0, 0, 8'h0, 0, 0, 0, d, seen);
   endtask

   initial
   begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      axr(REG_STAT);
      chk("stat_rst", 32'h0010_0000, rd);
      axw(REG_MADDR, 32'h10, 4'hF);
      foreach (mb[i]) axw(REG_MDATA, {24'h0, mb[i]}, 4'h1);
      axw(REG_CTRL, 32'h201, 4'h3);
      axr(REG_STAT);
      chk("stat_busy", 32'h0010_0201, rd);
      host.xfer(CMD_READ, 1'b1, 24'h10, 1, 8'h0, 0, 0, 1, d, seen);
      chk("busy_read", 32'h0, 32'(seen));
      repeat (WIPC) @(posedge clk);
      axr(REG_STAT);
      chk("stat_idle", 32'h0010_0200, rd);
      $display("busy test done");
      foreach (rows[i])
      begin
         host.xfer(rows[i].op, 1'b1, {16'h0, rows[i].a}, rows[i].al, 8'h0,
            rows[i].hm, rows[i].dc, rows[i].dl, d, seen);
         chk("row_data", {16'h0, rows[i].ex}, {16'h0, d});
         $display("row %0d done", i);
      end
      host.xfer(CMD_QIO, 1'b1, 24'h12, 4, 8'h20, 1, 4, 4, d, seen);
      chk("cont_first", 32'h0FD2, {16'h0, d});
      host.xfer(8'h0, 1'b0, 24'h13, 4, 8'h00, 1, 4, 4, d, seen);
      chk("cont_next", 32'hD281, {16'h0, d});
      axr(REG_STAT);
      chk("cont_off", 32'h0010_0200, rd);
      axr(8'h40);
      chk("unmapped", 32'(RESP_ERR), 32'(rr));
      $display("cont test done");
      // Answers held while ready stays low for one cycle
      stall = 1'b1;
      axw(REG_CTRL, 32'h202, 4'h3);
      axw(8'h40, 32'h0, 4'hF);
      chk("wr_unmapped", 32'(RESP_ERR), 32'(rb));
      axr(REG_STAT);
      chk("stall_read", 32'h0010_0202, rd);
      stall = 1'b0;
      op1(CMD_ARM);
      axr(REG_STAT);
      chk("armed", 32'h0011_0202, rd);
      op1(CMD_READ);
      op1(CMD_RST);
      axr(REG_STAT);
      chk("disarm", 32'h0010_0202, rd);
      op1(CMD_ARM);
      op1(CMD_RST);
      axr(REG_STAT);
      chk("in_rst", 32'h0002_0000, rd & 32'h0002_0000);
      host.xfer(CMD_READ, 1'b1, 24'h10, 1, 8'h0, 0, 0, 1, d, seen);
      chk("rst_refuse", 32'h0, 32'(seen));
      repeat (RSTC) @(posedge clk);
      axr(REG_STAT);
      chk("after_rst", 32'h0010_0000, rd);
      host.xfer(CMD_QIO, 1'b1, 24'h10, 4, 8'h0, 1, 4, 4, d, seen);
      chk("qe_gate", 32'h0, 32'(seen));
      $display("reset test done");
      finish_test();
   end
endmodule
